// *** core/ocr_pkg.sv ***
// Package with option-byte layout, register map and stabilization counts.
package ocr_pkg;

  // Layout of the second option byte.
  localparam int unsigned OPT_PKG_BIT     = 7;
  localparam int unsigned OPT_RSTLEN_BIT  = 6;
  localparam int unsigned OPT_SRC_HI      = 5;
  localparam int unsigned OPT_SRC_LO      = 4;
  localparam int unsigned OPT_RANGE_HI    = 3;
  localparam int unsigned OPT_RANGE_LO    = 1;
  localparam int unsigned OPT_PLLOFF_BIT  = 0;

  // Erased nonvolatile cells read as all ones.
  localparam logic [7:0] OPT_BLANK        = 8'hff;

  // Package select and clock source codes.
  localparam logic       PKG_32PIN        = 1'b0;
  localparam logic [1:0] SRC_RESONATOR    = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL     = 2'h3;

  // Frequency bands of the range field.
  localparam logic [2:0] RANGE_1_2MHZ     = 3'h0;
  localparam logic [2:0] RANGE_2_4MHZ     = 3'h1;
  localparam logic [2:0] RANGE_4_8MHZ     = 3'h2;
  localparam logic [2:0] RANGE_8_16MHZ    = 3'h3;

  // Stabilization lengths in CPU clock cycles; the CPU clock is clk_sys_i.
  localparam int unsigned STAB_LONG_CYC   = 4096;
  localparam int unsigned STAB_SHORT_CYC  = 256;
  localparam int unsigned STAB_CNT_W      = 13;
  localparam logic [12:0] STAB_LONG_LOAD  = 13'(STAB_LONG_CYC - 1);
  localparam logic [12:0] STAB_SHORT_LOAD = 13'(STAB_SHORT_CYC - 1);

  // Pad organisation and the unbonded pads of each package variant.
  localparam int unsigned PADS_PER_PORT   = 8;
  localparam int unsigned NUM_PORTS       = 4;
  localparam int unsigned NUM_PADS        = PADS_PER_PORT * NUM_PORTS;
  localparam logic [31:0] UNBONDED_32PIN  = 32'hff00_0000;
  localparam logic [31:0] UNBONDED_OTHER  = 32'h0000_0000;

  // AHB register byte offsets.
  localparam logic [7:0] REG_CFG_OFS      = 8'h00;
  localparam logic [7:0] REG_CTRL_OFS     = 8'h04;
  localparam logic [7:0] REG_PADPU_OFS    = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS   = 8'h0c;

  // Bit positions in the read-only configuration register.
  localparam int unsigned CFG_PKG_BIT     = 0;
  localparam int unsigned CFG_SRC_LO      = 1;
  localparam int unsigned CFG_RANGE_LO    = 3;
  localparam int unsigned CFG_PLLEN_BIT   = 6;
  localparam int unsigned CFG_SHORT_BIT   = 7;
  localparam int unsigned CFG_RSVSRC_BIT  = 8;
  localparam int unsigned CFG_PLLBAD_BIT  = 9;

  // Control and status bit positions.
  localparam int unsigned CTRL_HALT_BIT   = 0;
  localparam int unsigned STS_RUN_BIT     = 0;
  localparam int unsigned STS_HALT_BIT    = 1;
  localparam int unsigned STS_STAB_BIT    = 2;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_STAB,
    ST_RUN,
    ST_HALT
  } ocr_state_e;

endpackage : ocr_pkg

// *** core/ocr_stab_counter.sv ***
// Stabilization cycle counter: runs 4096 or 256 cycles and then pulses done.
module ocr_stab_counter (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  input  wire logic long_i,
  output logic      busy_o,
  output logic      done_o
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [12:0] cnt;
  } ocr_cnt_s;

  ocr_cnt_s r_reg;
  ocr_cnt_s r_next;

  // Load the chosen length on start, count down, pulse done after the last cycle.
  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start_i)
    begin
      r_next.busy = 1'b1;
      r_next.cnt  = long_i ? ocr_pkg::STAB_LONG_LOAD : ocr_pkg::STAB_SHORT_LOAD; // RULE_04
    end
    else if (r_reg.busy)
    begin
      if (r_reg.cnt == 13'h0)
      begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
      else
      begin
        r_next.cnt = r_reg.cnt - 13'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign busy_o = r_reg.busy;
  assign done_o = r_reg.done;

  a_short_length: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_04
    start_i && !long_i |-> ##257 done_o)
    else $error("short stabilization did not end after 256 cycles");

  a_done_after_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done_o |-> $past(busy_o) && !busy_o)
    else $error("done pulse without a preceding busy phase");

  a_busy_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_04
    start_i |=> busy_o [*8])
    else $error("counter stopped early after start");

endmodule // ocr_stab_counter

// *** core/ocr_option_clock_reset_config.sv ***
// Option-byte decoder and reset/halt-exit stabilization sequencer with AHB-Lite registers.
//
// Functional notes
// RULE_01: Bit 7 of the option byte selects the package, and zero means the 32-pin package.
// RULE_02: Every port has eight pads, and unbonded pads leave reset as inputs with pull-up.
// RULE_03: Software should leave the unbonded pad setup alone, since changing it costs current.
// RULE_04: Bit 6 sets the stabilization length: zero gives 4096 cycles, one gives 256 cycles.
// RULE_05: The chosen stabilization length is applied after reset and again on leaving halt.
// RULE_06: The 4096-cycle setting is advised whenever a resonator drives the clock.
// RULE_07: Bits 5:4 select the clock source: 00 resonator, 11 external, 01 and 10 reserved.
// RULE_08: With a resonator, bits 3:1 pick the oscillator current for bands from 1 to 16 MHz.
// RULE_09: Without a resonator, bits 3:1 report the normal operating frequency band instead.
// RULE_10: Bit 0 low enables the times-two clock multiplier, and bit 0 high bypasses it.
// RULE_11: The multiplier should only be enabled when the range field selects 2 to 4 MHz.
// RULE_12: Option bytes have no bus address, are written only by a programmer, and erased read ones.
// RULE_13: The option fields are sampled once after reset and held stable until the next reset.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
module ocr_option_clock_reset_config (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  option_byte_i,
  input  wire logic        wake_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             cpu_run_o,
  output logic             halted_o,
  output logic             package_select_bit_o,
  output logic             pkg_32pin_o,
  output logic             reset_length_select_o,
  output logic [1:0]       clock_source_type_o,
  output logic [2:0]       oscillator_range_select_o,
  output logic             osc_current_en_o,
  output logic [2:0]       osc_current_sel_o,
  output logic [2:0]       op_freq_range_o,
  output logic             pll_en_o,
  output logic [31:0]      pad_pullup_o
);

  typedef struct packed {
    ocr_pkg::ocr_state_e st;
    logic                pkg_bit;
    logic                rst_len;
    logic [1:0]          src;
    logic [2:0]          range;
    logic                cur_en;
    logic [2:0]          cur_sel;
    logic [2:0]          op_range;
    logic                pll_en;
    logic                halt_req;
    logic [31:0]         pad_pu;
    logic                cpu_run;
    logic                halted;
    logic                pkg32;
    logic                stab_start;
    logic                a_wr;
    logic [7:0]          a_addr;
    logic                ready;
    logic [31:0]         rdata;
  } ocr_core_s;

  ocr_core_s   r_reg;
  ocr_core_s   r_next;
  logic        stab_busy;
  logic        stab_done;
  logic        resonator;
  logic        addr_phase;
  logic [31:0] rd_mux;

  assign resonator  = (option_byte_i[ocr_pkg::OPT_SRC_HI:ocr_pkg::OPT_SRC_LO]
                       == ocr_pkg::SRC_RESONATOR);
  assign addr_phase = hsel_i && hready_i && htrans_i[1];

  // The counter is shared by the reset phase and by every halt exit.
  ocr_stab_counter u_stab (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (r_reg.stab_start),
    .long_i    (!r_reg.rst_len),
    .busy_o    (stab_busy),
    .done_o    (stab_done)
  );

  // Read mux: the decoded option values are visible, the raw byte has no address.
  always_comb
  begin
    rd_mux = 32'h0;
    case (haddr_i[7:0])
      ocr_pkg::REG_CFG_OFS:
      begin
        rd_mux[ocr_pkg::CFG_PKG_BIT]                         = r_reg.pkg_bit;
        rd_mux[ocr_pkg::CFG_SRC_LO +: 2]                     = r_reg.src;
        rd_mux[ocr_pkg::CFG_RANGE_LO +: 3]                   = r_reg.range;
        rd_mux[ocr_pkg::CFG_PLLEN_BIT]                       = r_reg.pll_en;
        rd_mux[ocr_pkg::CFG_SHORT_BIT]                       = r_reg.rst_len;
        rd_mux[ocr_pkg::CFG_RSVSRC_BIT]                      = (r_reg.src == 2'h1) ||
                                                               (r_reg.src == 2'h2); // RULE_07
        rd_mux[ocr_pkg::CFG_PLLBAD_BIT]                      = r_reg.pll_en &&
                                             (r_reg.range != ocr_pkg::RANGE_2_4MHZ); // RULE_11
      end
      ocr_pkg::REG_CTRL_OFS:   rd_mux[ocr_pkg::CTRL_HALT_BIT] = r_reg.halt_req;
      ocr_pkg::REG_PADPU_OFS:  rd_mux = r_reg.pad_pu;
      ocr_pkg::REG_STATUS_OFS:
      begin
        rd_mux[ocr_pkg::STS_RUN_BIT]  = r_reg.cpu_run;
        rd_mux[ocr_pkg::STS_HALT_BIT] = r_reg.halted;
        rd_mux[ocr_pkg::STS_STAB_BIT] = stab_busy;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Sequencer, option capture and bus slave.
  always_comb
  begin
    r_next            = r_reg;
    r_next.stab_start = 1'b0;
    r_next.ready      = 1'b1;
    r_next.rdata      = 32'h0;
    r_next.a_wr       = 1'b0;
    case (r_reg.st)
      ocr_pkg::ST_SAMPLE:
      begin
        // One capture at reset release; the fields never load again. // RULE_13
        r_next.pkg_bit    = option_byte_i[ocr_pkg::OPT_PKG_BIT]; // RULE_01
        r_next.rst_len    = option_byte_i[ocr_pkg::OPT_RSTLEN_BIT]; // RULE_04
        r_next.src        = option_byte_i[ocr_pkg::OPT_SRC_HI:ocr_pkg::OPT_SRC_LO]; // RULE_07
        r_next.range      = option_byte_i[ocr_pkg::OPT_RANGE_HI:ocr_pkg::OPT_RANGE_LO];
        r_next.cur_en     = resonator; // RULE_08
        r_next.cur_sel    = resonator ? r_next.range : 3'h0; // RULE_08
        r_next.op_range   = resonator ? 3'h0 : r_next.range; // RULE_09
        r_next.pll_en     = !option_byte_i[ocr_pkg::OPT_PLLOFF_BIT]; // RULE_10
        r_next.pkg32      = (r_next.pkg_bit == ocr_pkg::PKG_32PIN); // RULE_01
        r_next.pad_pu     = (r_next.pkg_bit == ocr_pkg::PKG_32PIN) ?
                            ocr_pkg::UNBONDED_32PIN : ocr_pkg::UNBONDED_OTHER; // RULE_02
        r_next.stab_start = 1'b1; // RULE_05
        r_next.st         = ocr_pkg::ST_STAB;
      end
      ocr_pkg::ST_STAB:
      begin
        if (stab_done)
        begin
          r_next.cpu_run = 1'b1;
          r_next.st      = ocr_pkg::ST_RUN;
        end
      end
      ocr_pkg::ST_RUN:
      begin
        if (r_reg.halt_req)
        begin
          r_next.halt_req = 1'b0;
          r_next.cpu_run  = 1'b0;
          r_next.halted   = 1'b1;
          r_next.st       = ocr_pkg::ST_HALT;
        end
      end
      ocr_pkg::ST_HALT:
      begin
        if (wake_i)
        begin
          r_next.halted     = 1'b0;
          r_next.stab_start = 1'b1; // RULE_05
          r_next.st         = ocr_pkg::ST_STAB;
        end
      end
      default: r_next.st = ocr_pkg::ST_SAMPLE;
    endcase
    // Address phase: latch the target and present read data for a zero-wait answer.
    if (addr_phase)
    begin
      r_next.a_wr   = hwrite_i;
      r_next.a_addr = haddr_i[7:0];
      if (!hwrite_i)
      begin
        r_next.rdata = rd_mux;
      end
    end
    // Data phase write; a new halt request wins over the clear by the sequencer.
    if (r_reg.a_wr)
    begin
      case (r_reg.a_addr)
        ocr_pkg::REG_CTRL_OFS:
        begin
          if (hwdata_i[ocr_pkg::CTRL_HALT_BIT])
          begin
            r_next.halt_req = 1'b1;
          end
        end
        // Writable, but changing unbonded pads only adds current. // RULE_03
        ocr_pkg::REG_PADPU_OFS: r_next.pad_pu = hwdata_i;
        // Other offsets ignore the write; a new address phase latched above must survive.
        default:
        begin
        end
      endcase
    end
  end

  // State register; erased-byte decode stands until the capture. // RULE_12
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r_reg          <= '0;
      r_reg.st       <= ocr_pkg::ST_SAMPLE;
      r_reg.pkg_bit  <= ocr_pkg::OPT_BLANK[ocr_pkg::OPT_PKG_BIT];
      r_reg.rst_len  <= ocr_pkg::OPT_BLANK[ocr_pkg::OPT_RSTLEN_BIT];
      r_reg.src      <= ocr_pkg::OPT_BLANK[ocr_pkg::OPT_SRC_HI:ocr_pkg::OPT_SRC_LO];
      r_reg.range    <= ocr_pkg::OPT_BLANK[ocr_pkg::OPT_RANGE_HI:ocr_pkg::OPT_RANGE_LO];
      r_reg.op_range <= ocr_pkg::OPT_BLANK[ocr_pkg::OPT_RANGE_HI:ocr_pkg::OPT_RANGE_LO];
      r_reg.ready    <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs, each straight from the state register except hresp_o, which is tied to zero.
  assign hreadyout_o               = r_reg.ready;
  assign hresp_o                   = 1'b0;
  assign hrdata_o                  = r_reg.rdata;
  assign cpu_run_o                 = r_reg.cpu_run;
  assign halted_o                  = r_reg.halted;
  assign package_select_bit_o      = r_reg.pkg_bit;
  assign pkg_32pin_o               = r_reg.pkg32;
  assign reset_length_select_o     = r_reg.rst_len;
  assign clock_source_type_o       = r_reg.src;
  assign oscillator_range_select_o = r_reg.range;
  assign osc_current_en_o          = r_reg.cur_en;
  assign osc_current_sel_o         = r_reg.cur_sel;
  assign op_freq_range_o           = r_reg.op_range;
  assign pll_en_o                  = r_reg.pll_en;

  // One pull-up enable per pad.
  for (genvar g = 0; g < ocr_pkg::NUM_PADS; g++)
  begin : g_pad
    assign pad_pullup_o[g] = r_reg.pad_pu[g];
  end

  // Helper: length of each stabilization phase as seen by the sequencer.
  logic [12:0] h_len;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      h_len <= 13'h0;
    end
    else if (r_reg.stab_start)
    begin
      h_len <= 13'h0;
    end
    else if (stab_busy)
    begin
      h_len <= h_len + 13'h1;
    end
  end

  a_stab_length: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_05
    stab_done |-> h_len == (r_reg.rst_len ? 13'd256 : 13'd4096))
    else $error("stabilization length does not match the option bit");

  a_capture_decode: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_10
    $past(r_reg.st) == ocr_pkg::ST_SAMPLE && r_reg.st == ocr_pkg::ST_STAB |->
      pll_en_o == !$past(option_byte_i[0]) &&
      pkg_32pin_o == !$past(option_byte_i[7]))
    else $error("option fields decoded wrongly at capture");

  a_range_route: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_09
    r_reg.st != ocr_pkg::ST_SAMPLE && clock_source_type_o != 2'h0 |->
      !osc_current_en_o && op_freq_range_o == oscillator_range_select_o)
    else $error("range field not routed to operating band");

  a_fields_held: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_13
    r_reg.st != ocr_pkg::ST_SAMPLE |=> $stable(r_reg.src) && $stable(r_reg.range) &&
      $stable(pll_en_o) && $stable(r_reg.rst_len))
    else $error("option fields changed after capture");

  a_halt_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RULE_05
    halted_o && wake_i |=> !cpu_run_o && r_reg.stab_start ##1 stab_busy)
    else $error("halt exit did not restart stabilization");

  a_ahb_okay: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    hreadyout_o && !hresp_o)
    else $error("slave answered with wait or error");

  c_short_boot: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    stab_done && r_reg.rst_len);
  c_long_boot: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    stab_done && !r_reg.rst_len);
  c_halt_exit: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    halted_o && wake_i);

endmodule // ocr_option_clock_reset_config

// *** tb/ocr_nv_model.sv ***
// Behavioural model of the nonvolatile option cells and of the external programmer.
module ocr_nv_model (
  input  wire logic       clk_sys_i,
  input  wire logic       prog_mode_i,
  input  wire logic       erase_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] opt_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cells_reg = 8'hff;

  // Cells change only in programming mode, and programming clears bits but never sets them.
  always @(posedge clk_sys_i)
  begin
    if (prog_mode_i && erase_i)
      cells_reg <= 8'hff;
    else if (prog_mode_i && wr_i)
      cells_reg <= cells_reg & wr_data_i;
  end

  // The cells have no bus address; the device only sees their value.
  assign opt_o = cells_reg;
endmodule // ocr_nv_model

// *** tb/ocr_option_clock_reset_config_tb_top.sv ***
// Self-checking testbench of the option-byte decoder and stabilization sequencer.
module ocr_option_clock_reset_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_b, wake, hsel, hwrite, prog, erase, nv_wr;
  logic [31:0] haddr, hwdata, hrdata, pads;
  logic [1:0]  htrans, src;
  logic [2:0]  rng, cur_sel, op_rng;
  logic [7:0]  nv_data, opt, cur;
  logic        hreadyout, hresp, cpu_run, halted, pkg_bit, pkg32, rstlen, cur_en, pll_en;
  logic [15:0] fields;
  logic [31:0] rd;
  int          fail_count, cmp_count;

  ocr_nv_model NV (.clk_sys_i(clk), .prog_mode_i(prog), .erase_i(erase), .wr_i(nv_wr),
    .wr_data_i(nv_data), .opt_o(opt));

  ocr_option_clock_reset_config DUT (.clk_sys_i(clk), .rst_b_i(rst_b), .option_byte_i(opt),
    .wake_i(wake), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .cpu_run_o(cpu_run), .halted_o(halted),
    .package_select_bit_o(pkg_bit), .pkg_32pin_o(pkg32), .reset_length_select_o(rstlen),
    .clock_source_type_o(src), .oscillator_range_select_o(rng), .osc_current_en_o(cur_en),
    .osc_current_sel_o(cur_sel), .op_freq_range_o(op_rng), .pll_en_o(pll_en),
    .pad_pullup_o(pads));

  // All decoded fields side by side, so one comparison covers the whole decode.
  assign fields = {pkg_bit, pkg32, rstlen, src, rng, cur_en, cur_sel, op_rng, pll_en};

  // Clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Expected decode of one option byte.
  function automatic logic [15:0] exp_fields(input logic [7:0] b);
    logic res;
    res = (b[5:4] == 2'h0);
    return {b[7], ~b[7], b[6], b[5:4], b[3:1], res, res ? b[3:1] : 3'h0,
      res ? 3'h0 : b[3:1], ~b[0]};
  endfunction

  // Expected read-only configuration word.
  function automatic logic [31:0] exp_cfg(input logic [7:0] b);
    return {22'h0, ~b[0] && b[3:1] != 3'h1, b[5:4] == 2'h1 || b[5:4] == 2'h2, b[6], ~b[0],
      b[3:1], b[5:4], b[7]};
  endfunction

  // Only the small package leaves the top port unbonded and pulled up.
  function automatic logic [31:0] exp_pads(input logic [7:0] b);
    return b[7] ? 32'h0 : 32'hff00_0000;
  endfunction

  // Stabilization length chosen by the reset length bit.
  function automatic int unsigned exp_len(input logic [7:0] b);
    return b[6] ? ocr_pkg::STAB_SHORT_CYC : ocr_pkg::STAB_LONG_CYC;
  endfunction

  // Keeps a random byte within what the configuring party is allowed to program.
  function automatic logic [7:0] legal(input logic [7:0] b);
    logic [7:0] v;
    v = b;
    if (v[5:4] == 2'h0)
      v[6] = 1'b0;
    if (v[3:1] != 3'h1)
      v[0] = 1'b1;
    return v;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Waits for rising edges until hready is sampled high; values read there are pre-edge ones.
  task automatic wait_ready;
    int i;
    i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && i < 16)
    begin
      @(posedge clk);
      i++;
    end
    check(32'(hreadyout), 32'h1, "hready");
  endtask

  // One single AHB-Lite word transfer: address phase, then data phase; read data at its end.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
  endtask

  // Counts cycles until the CPU runs and compares with the selected length.
  task automatic stab_wait(input int unsigned len);
    int unsigned n;
    n = 0;
    while (cpu_run !== 1'b1 && n < len + 20)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= len && n <= len + 6), 32'h1, "stabilization length");
  endtask

  // Programs the cells during reset, releases it and checks the decode.
  task automatic boot(input logic [7:0] b);
    @(posedge clk);
    rst_b <= 1'b0;
    prog <= 1'b1;
    erase <= 1'b1;
    @(posedge clk);
    erase <= 1'b0;
    nv_wr <= 1'b1;
    nv_data <= b;
    @(posedge clk);
    nv_wr <= 1'b0;
    prog <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(fields), 32'(exp_fields(8'hff)), "reset values");
    rst_b <= 1'b1;
    cur = b;
    stab_wait(exp_len(b));
    check(32'(fields), 32'(exp_fields(b)), "decode");
    check(pads, exp_pads(b), "pad pull-ups");
    ahb(1'b0, ocr_pkg::REG_CFG_OFS, 32'h0, rd);
    check(rd, exp_cfg(b), "config word");
    ahb(1'b0, ocr_pkg::REG_PADPU_OFS, 32'h0, rd);
    check(rd, exp_pads(b), "pad register");
    $display("test boot %h done", b);
  endtask

  // Main sequence: corner bytes, random bytes, then halt, wake and hold checks.
  initial
  begin
    logic [7:0] corners [5];
    corners = '{8'hff, 8'h02, 8'hb7, 8'h5d, 8'h6b};
    rst_b = 1'b0;
    wake = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    prog = 1'b0;
    erase = 1'b0;
    nv_wr = 1'b0;
    nv_data = 8'hff;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(18568));
    foreach (corners[i])
      boot(corners[i]);
    for (int i = 0; i < 4; i++)
      boot(legal(8'($urandom())));
    boot(8'h7f);
    ahb(1'b1, ocr_pkg::REG_CFG_OFS, 32'hffff_ffff, rd);
    ahb(1'b0, ocr_pkg::REG_CFG_OFS, 32'h0, rd);
    check(rd, exp_cfg(cur), "read-only config");
    ahb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b1, ocr_pkg::REG_CTRL_OFS, 32'h0, rd);
    repeat (3) @(posedge clk);
    check({30'h0, halted, cpu_run}, 32'h1, "no halt on zero");
    ahb(1'b1, ocr_pkg::REG_CTRL_OFS, 32'h1, rd);
    repeat (3) @(posedge clk);
    check({30'h0, halted, cpu_run}, 32'h2, "halt entered");
    ahb(1'b0, ocr_pkg::REG_STATUS_OFS, 32'h0, rd);
    check(rd, 32'h2, "halt status");
    $display("test halt done");
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    stab_wait(exp_len(cur));
    ahb(1'b0, ocr_pkg::REG_STATUS_OFS, 32'h0, rd);
    check(rd, 32'h1, "run status");
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    check({30'h0, halted, cpu_run}, 32'h1, "wake while running");
    $display("test wake done");
    prog <= 1'b1;
    erase <= 1'b1;
    @(posedge clk);
    erase <= 1'b0;
    nv_wr <= 1'b1;
    nv_data <= 8'h02;
    @(posedge clk);
    nv_wr <= 1'b0;
    prog <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(fields), 32'(exp_fields(cur)), "held decode");
    check(pads, exp_pads(cur), "held pads");
    $display("test hold done");
    stop_test();
  end

  // Watchdog sized well above the sum of all stabilization runs.
  initial
  begin
    #900000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // ocr_option_clock_reset_config_tb_top
